/* File: design/sfue_top.v */
`timescale 1ns/1ns
`default_nettype none
`include "sfue_map.vh"
module sfue_top #(
  parameter [31:0] HOLD_CYC = `SFUE_HOLD_CYC,
  parameter [31:0] POLL_CYC = `SFUE_POLL_CYC,
  parameter [31:0] DIV_CFG  = `SFUE_DIV_CFG,
  parameter [31:0] DIV_UPG  = `SFUE_DIV_UPG
) (
  input  wire       i_clock,
  input  wire       i_reset_n,
  input  wire       i_mode_select_low,
  input  wire       i_mode_select_high,
  input  wire       i_status_in,
  input  wire       i_rxd,
  input  wire       i_image_done,
  output wire       o_txd,
  output wire       o_status_oe,
  output reg        o_upgrade_ff,
  output reg        o_sys_reset_ff,
  output reg        o_app_start_ff,
  output reg        o_frame_valid_ff,
  output reg  [7:0] o_frame_data_ff
);
  localparam [5:0] ST_STRAP = 6'h01, ST_CFG = 6'h02, ST_ACK = 6'h04,
                   ST_RST = 6'h08, ST_POLL = 6'h10, ST_LOAD = 6'h20;
  reg [5:0]  state_ff;
  reg [1:0]  ms0_ff, ms1_ff, st_ff;
  reg [31:0] cnt_ff;
  reg [2:0]  match_ff;
  reg [3:0]  ack_idx_ff;
  reg        tx_go_ff;
  reg [7:0]  tx_byte_ff;
  reg        boot_ff;
  wire       tx_ready, rx_valid;
  wire [7:0] rx_data;
  wire       cfg_mode = ms0_ff[1] & ms1_ff[1];
  wire [15:0] div = (state_ff == ST_CFG || state_ff == ST_ACK) ?
                    DIV_CFG[15:0] : DIV_UPG[15:0];

  function [7:0] req_char;
    input [2:0] i;
    case (i)
      3'h0: req_char = 8'h41;
      3'h1: req_char = 8'h54;
      3'h2: req_char = 8'h2b;
      3'h3: req_char = 8'h49;
      3'h4: req_char = 8'h41;
      default: req_char = 8'h50;
    endcase
  endfunction
  function [7:0] ack_char;
    input [3:0] i;
    case (i)
      4'h6: ack_char = 8'h3d;
      4'h7: ack_char = 8'h4f;
      4'h8: ack_char = 8'h4b;
      default: ack_char = req_char(i[2:0]);
    endcase
  endfunction

  // status line is only sampled; device never drives it here
  assign o_status_oe = 1'b0;

  sfue_uart u_uart (
    .i_clock       (i_clock),
    .i_reset_n     (i_reset_n),
    .i_div         (div),
    .i_rxd         (i_rxd),
    .i_tx_valid    (tx_go_ff),
    .i_tx_data     (tx_byte_ff),
    .o_tx_ready    (tx_ready),
    .o_txd_ff      (o_txd),
    .o_rx_valid_ff (rx_valid),
    .o_rx_data_ff  (rx_data)
  );

  always @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_ff         <= ST_STRAP;
      ms0_ff           <= 2'h0;
      ms1_ff           <= 2'h0;
      // reset low: a high value would leave the strap window before the pin arrives
      st_ff            <= 2'h0;
      cnt_ff           <= 32'h0;
      match_ff         <= 3'h0;
      ack_idx_ff       <= 4'h0;
      tx_go_ff         <= 1'b0;
      tx_byte_ff       <= 8'h00;
      boot_ff          <= 1'b0;
      o_upgrade_ff     <= 1'b0;
      o_sys_reset_ff   <= 1'b0;
      o_app_start_ff   <= 1'b0;
      o_frame_valid_ff <= 1'b0;
      o_frame_data_ff  <= 8'h00;
    end else begin
      ms0_ff           <= {ms0_ff[0], i_mode_select_low};
      ms1_ff           <= {ms1_ff[0], i_mode_select_high};
      st_ff            <= {st_ff[0], i_status_in};
      tx_go_ff         <= 1'b0;
      o_sys_reset_ff   <= 1'b0;
      o_app_start_ff   <= 1'b0;
      o_frame_valid_ff <= 1'b0;
      case (state_ff)
        ST_STRAP: begin
          // status must stay low the whole hold window after power-up
          if (boot_ff || st_ff[1]) begin
            state_ff <= ST_CFG;
            cnt_ff   <= 32'h0;
          end else if (cnt_ff >= HOLD_CYC - 32'h1) begin
            state_ff     <= ST_POLL;
            o_upgrade_ff <= 1'b1;
            cnt_ff       <= 32'h0;
          end else begin
            cnt_ff <= cnt_ff + 32'h1;
          end
        end
        ST_CFG: begin
          if (rx_valid && cfg_mode) begin
            if (rx_data == req_char(match_ff)) begin
              if (match_ff == 3'h5) begin
                state_ff   <= ST_ACK;
                ack_idx_ff <= 4'h0;
                match_ff   <= 3'h0;
              end else begin
                match_ff <= match_ff + 3'h1;
              end
            end else begin
              match_ff <= (rx_data == 8'h41) ? 3'h1 : 3'h0;
            end
          end
        end
        ST_ACK: begin
          if (tx_ready && !tx_go_ff) begin
            if (ack_idx_ff == 4'h9) begin
              state_ff       <= ST_RST;
              o_sys_reset_ff <= 1'b1;
            end else begin
              tx_go_ff   <= 1'b1;
              tx_byte_ff <= ack_char(ack_idx_ff);
              ack_idx_ff <= ack_idx_ff + 4'h1;
            end
          end
        end
        ST_RST: begin
          state_ff     <= ST_POLL;
          o_upgrade_ff <= 1'b1;
          cnt_ff       <= 32'h0;
        end
        ST_POLL: begin
          if (rx_valid && (rx_data == `SFUE_CH_SOH || rx_data == `SFUE_CH_STX)) begin
            state_ff         <= ST_LOAD;
            o_frame_valid_ff <= 1'b1;
            o_frame_data_ff  <= rx_data;
          end else if (cnt_ff >= POLL_CYC - 32'h1) begin
            cnt_ff <= 32'h0;
            if (tx_ready) begin
              tx_go_ff   <= 1'b1;
              tx_byte_ff <= `SFUE_CH_C;
            end
          end else begin
            cnt_ff <= cnt_ff + 32'h1;
          end
        end
        ST_LOAD: begin
          if (rx_valid) begin
            o_frame_valid_ff <= 1'b1;
            o_frame_data_ff  <= rx_data;
          end
          if (i_image_done) begin
            state_ff       <= ST_CFG;
            o_upgrade_ff   <= 1'b0;
            o_sys_reset_ff <= 1'b1;
            o_app_start_ff <= 1'b1;
            boot_ff        <= 1'b1;
          end
        end
        default: state_ff <= ST_STRAP;
      endcase
    end
  end
endmodule
`default_nettype wire

/* File: design/sfue_map.vh */
// What this block does
// - configuration mode talks at 9600 baud
// - only two upgrade entries: command, status low
// - upgrade wait repeats C at 115200
// - AT+IAP answered AT+IAP=OK, then self reset
// - full image received: reset into application
`ifndef SFUE_MAP_VH
`define SFUE_MAP_VH
`define SFUE_CLK_HZ        250000000
`define SFUE_BAUD_CFG      9600
`define SFUE_BAUD_UPG      115200
`define SFUE_DIV_CFG       (`SFUE_CLK_HZ / `SFUE_BAUD_CFG)
`define SFUE_DIV_UPG       (`SFUE_CLK_HZ / `SFUE_BAUD_UPG)
`define SFUE_HOLD_MS       1000
`define SFUE_HOLD_CYC      (`SFUE_CLK_HZ / 1000 * `SFUE_HOLD_MS)
`define SFUE_POLL_CYC      (`SFUE_CLK_HZ / 4)
`define SFUE_CH_C          8'h43
`define SFUE_CH_SOH        8'h01
`define SFUE_CH_STX        8'h02
`endif

/* File: design/sfue_uart.v */
`timescale 1ns/1ns
`default_nettype none
// 8N1 serial transmitter and receiver; divider reloaded at every bit
module sfue_uart (
  input  wire        i_clock,
  input  wire        i_reset_n,
  input  wire [15:0] i_div,
  input  wire        i_rxd,
  input  wire        i_tx_valid,
  input  wire [7:0]  i_tx_data,
  output wire        o_tx_ready,
  output reg         o_txd_ff,
  output reg         o_rx_valid_ff,
  output reg  [7:0]  o_rx_data_ff
);
  reg [1:0]  rx_sync_ff;
  reg [15:0] tx_cnt_ff;
  reg [3:0]  tx_bit_ff;
  reg [8:0]  tx_sh_ff;
  reg [15:0] rx_cnt_ff;
  reg [3:0]  rx_bit_ff;
  reg [7:0]  rx_sh_ff;
  wire       rxd = rx_sync_ff[1];

  assign o_tx_ready = (tx_bit_ff == 4'h0);

  always @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rx_sync_ff    <= 2'h3;
      tx_cnt_ff     <= 16'h0000;
      tx_bit_ff     <= 4'h0;
      tx_sh_ff      <= 9'h1ff;
      o_txd_ff      <= 1'b1;
      rx_cnt_ff     <= 16'h0000;
      rx_bit_ff     <= 4'h0;
      rx_sh_ff      <= 8'h00;
      o_rx_valid_ff <= 1'b0;
      o_rx_data_ff  <= 8'h00;
    end else begin
      rx_sync_ff    <= {rx_sync_ff[0], i_rxd};
      o_rx_valid_ff <= 1'b0;
      if (tx_bit_ff == 4'h0) begin
        if (i_tx_valid) begin
          tx_sh_ff  <= {1'b1, i_tx_data};
          o_txd_ff  <= 1'b0;
          tx_bit_ff <= 4'ha;
          tx_cnt_ff <= i_div - 16'h0001;
        end
      end else if (tx_cnt_ff != 16'h0000) begin
        tx_cnt_ff <= tx_cnt_ff - 16'h0001;
      end else begin
        tx_cnt_ff <= i_div - 16'h0001;
        tx_bit_ff <= tx_bit_ff - 4'h1;
        o_txd_ff  <= (tx_bit_ff == 4'h1) ? 1'b1 : tx_sh_ff[0];
        tx_sh_ff  <= {1'b1, tx_sh_ff[8:1]};
      end
      // sample mid-bit; a false start is dropped at the half point
      if (rx_bit_ff == 4'h0) begin
        if (!rxd) begin
          rx_bit_ff <= 4'ha;
          rx_cnt_ff <= {1'b0, i_div[15:1]};
        end
      end else if (rx_cnt_ff != 16'h0000) begin
        rx_cnt_ff <= rx_cnt_ff - 16'h0001;
      end else begin
        rx_cnt_ff <= i_div - 16'h0001;
        rx_bit_ff <= rx_bit_ff - 4'h1;
        if (rx_bit_ff == 4'ha && rxd) begin
          rx_bit_ff <= 4'h0;
        end else if (rx_bit_ff == 4'h1) begin
          rx_bit_ff     <= 4'h0;
          o_rx_valid_ff <= rxd;
          o_rx_data_ff  <= rx_sh_ff;
        end else if (rx_bit_ff != 4'ha) begin
          rx_sh_ff <= {rxd, rx_sh_ff[7:1]};
        end
      end
    end
  end
endmodule
`default_nettype wire

/* File: test/sfue_chk.sv */
`timescale 1ns/1ns
`default_nettype none
module sfue_chk #(
  parameter [31:0] HOLD_CYC = 32'd100,
  parameter [31:0] POLL_CYC = 32'd2000
) (
  input wire logic       i_clock,
  input wire logic       i_reset_n,
  input wire logic       i_mode_select_low,
  input wire logic       i_mode_select_high,
  input wire logic       i_status_in,
  input wire logic       i_rxd,
  input wire logic       i_image_done,
  input wire logic       o_txd,
  input wire logic       o_status_oe,
  input wire logic       o_upgrade_ff,
  input wire logic       o_sys_reset_ff,
  input wire logic       o_app_start_ff,
  input wire logic       o_frame_valid_ff,
  input wire logic [7:0] o_frame_data_ff
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_reset_n);
  status_undriven_a: assert property (o_status_oe == 1'b0)
    else $error("status line driven");
  reset_pulse_a: assert property (o_sys_reset_ff |=> !o_sys_reset_ff)
    else $error("self reset longer than one cycle");
  app_pulse_a: assert property (o_app_start_ff |=> !o_app_start_ff)
    else $error("app start longer than one cycle");
  app_with_reset_a: assert property (o_app_start_ff |-> o_sys_reset_ff)
    else $error("app start without self reset");
  app_leaves_a: assert property (o_app_start_ff |=> !o_upgrade_ff)
    else $error("upgrade state kept after app start");
  upgrade_exit_a: assert property ($fell(o_upgrade_ff) |->
    o_app_start_ff || $past(o_app_start_ff))
    else $error("upgrade left without app start");
  cmd_reset_upg_a: assert property (o_sys_reset_ff && !o_app_start_ff |=> o_upgrade_ff)
    else $error("upgrade state not entered after self reset");
  frame_in_upg_a: assert property (o_frame_valid_ff |-> o_upgrade_ff)
    else $error("frame byte outside upgrade");
  start_bit_len_a: assert property ($fell(o_txd) |=> !o_txd [*8])
    else $error("start bit too short");
endmodule
bind sfue_top sfue_chk #(.HOLD_CYC(HOLD_CYC), .POLL_CYC(POLL_CYC)) chk (.*);
`default_nettype wire

/* File: test/sfue_host.sv */
`timescale 1ns/1ns
`default_nettype none
module sfue_host (
  input  wire logic i_clock,
  input  wire logic i_txd,
  output var  logic o_rxd
);
  int         bit_t = 100;
  int         n_rx = 0;
  logic [7:0] last;
  logic [7:0] b;
  logic [7:0] log_q [0:15];
  initial o_rxd = 1'b1;
  // 8n1 lsb first, line left high between bytes
  task automatic send(input logic [7:0] d);
    logic [9:0] f;
    f = {1'b1, d, 1'b0};
    for (int k = 0; k < 10; k++) begin
      @(posedge i_clock);
      #1 o_rxd = f[k];
      repeat (bit_t - 1) @(posedge i_clock);
    end
  endtask
  // mid-bit sampling at bit_t; a wrong rate shows as a wrong char
  always begin
    @(negedge i_txd);
    repeat (bit_t + bit_t / 2) @(posedge i_clock);
    for (int k = 0; k < 8; k++) begin
      b[k] = i_txd;
      repeat (bit_t) @(posedge i_clock);
    end
    last = b;
    log_q[n_rx % 16] = b;
    n_rx++;
  end
endmodule
`default_nettype wire

/* File: test/testbench.sv */
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin err_total++; \
  $display("[FAIL] %s exp %h got %h", n, e, s); end end
module testbench;
  logic       i_clock = 1'b0;
  logic       i_reset_n = 1'b0;
  logic [1:0] msel;
  logic       st = 1'b0;
  logic       img = 1'b0;
  wire        rxd, txd, oe, upg, srst, app, fv;
  wire  [7:0] fd;
  int         err_total = 0, samples_checked = 0, seed = 32'hb545, i, nc, nf = 0, n_rst = 0;
  logic [47:0] req_str = 48'h41542b494150;
  logic [7:0] sb, got;
  logic       seen_app = 1'b0;
  always #2 i_clock = ~i_clock;
  // shortened divisors set a 1:2 rate ratio, not the 1:12 of 9600 to 115200, visible to the host model
  sfue_top #(.HOLD_CYC(32'd100), .POLL_CYC(32'd2000), .DIV_CFG(32'd200),
             .DIV_UPG(32'd100)) DUT (
    .i_clock(i_clock), .i_reset_n(i_reset_n), .i_mode_select_low(msel[0]),
    .i_mode_select_high(msel[1]), .i_status_in(st), .i_rxd(rxd),
    .i_image_done(img), .o_txd(txd), .o_status_oe(oe), .o_upgrade_ff(upg),
    .o_sys_reset_ff(srst), .o_app_start_ff(app), .o_frame_valid_ff(fv),
    .o_frame_data_ff(fd));
  sfue_host h (.i_clock(i_clock), .i_txd(txd), .o_rxd(rxd));
  always @(posedge i_clock) begin
    if (fv) begin
      got <= fd;
      nf <= nf + 1;
    end
    if (app && srst) seen_app <= 1'b1;
    if (srst && !app) n_rst <= n_rst + 1;
  end
  function automatic logic [7:0] exp_ack(input int k);
    logic [71:0] s;
    s = 72'h41542b4941503d4f4b;
    return s[71 - 8 * k -: 8];
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clock);
    #1;
  endtask
  task wrap_up;
    $display("checked %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    #320000;
    err_total++;
    wrap_up;
  end
  initial begin
    msel = 2'($random(seed));
    cyc(10);
    i_reset_n = 1'b1;
    cyc(50);
    `CHK("early upgrade", 1'b0, upg)
    cyc(70);
    `CHK("strap upgrade", 1'b1, upg)
    for (i = 0; i < 6000 && h.n_rx == 0; i++) cyc(1);
    `CHK("ready char", 8'h43, h.last)
    st = 1'b1;
    sb = 8'($random(seed) & 1) + 8'h01;
    msel = 2'($random(seed));
    h.send(sb);
    cyc(5);
    `CHK("frame count", 1, nf)
    `CHK("frame byte", sb, got)
    // let a poll already on the wire finish before counting
    cyc(1200);
    nc = h.n_rx;
    cyc(6000);
    `CHK("polls after frame", nc, h.n_rx)
    img = 1'b1;
    cyc(1);
    img = 1'b0;
    for (i = 0; i < 50 && !seen_app; i++) cyc(1);
    `CHK("app start", 1'b1, seen_app)
    cyc(2);
    `CHK("upgrade left", 1'b0, upg)
    h.bit_t = 200;
    msel = 2'($random(seed));
    if (msel == 2'b11) msel = 2'b01;
    nc = h.n_rx;
    for (i = 0; i < 6; i++) h.send(req_str[47 - 8 * i -: 8]);
    cyc(2500);
    `CHK("refused reply", nc, h.n_rx)
    `CHK("refused upgrade", 1'b0, upg)
    msel = 2'b11;
    cyc(5);
    for (i = 0; i < 6; i++) h.send(req_str[47 - 8 * i -: 8]);
    for (i = 0; i < 25000 && h.n_rx < nc + 9; i++) cyc(1);
    h.bit_t = 100;
    for (i = 0; i < 9; i++) `CHK("reply", exp_ack(i), h.log_q[(nc + i) % 16])
    for (i = 0; i < 500 && !upg; i++) cyc(1);
    `CHK("command reset", 1, n_rst)
    `CHK("command upgrade", 1'b1, upg)
    nc = h.n_rx;
    for (i = 0; i < 6000 && h.n_rx == nc; i++) cyc(1);
    `CHK("ready after command", 8'h43, h.last)
    wrap_up;
  end
endmodule
`default_nettype wire
